/* File: common/pwm_pkg.sv */
`default_nettype none

package pwm_pkg;

    localparam int unsigned TW = 16;

    // Register indexes; byte address is index times four
    localparam logic [3:0] IDX_CTRL   = 4'h0;
    localparam logic [3:0] IDX_P0_C0  = 4'h1;
    localparam logic [3:0] IDX_P0_C1  = 4'h2;
    localparam logic [3:0] IDX_P0_C2  = 4'h3;
    localparam logic [3:0] IDX_P0_LEN = 4'h4;
    localparam logic [3:0] IDX_P1_C0  = 4'h5;
    localparam logic [3:0] IDX_P1_C1  = 4'h6;
    localparam logic [3:0] IDX_P1_C2  = 4'h7;
    localparam logic [3:0] IDX_P1_LEN = 4'h8;
    localparam logic [3:0] IDX_S_C0   = 4'h9;
    localparam logic [3:0] IDX_S_C1   = 4'ha;
    localparam logic [3:0] IDX_S_LEN  = 4'hb;
    localparam logic [3:0] IDX_ICLR   = 4'hc;
    localparam logic [3:0] IDX_MASK   = 4'hd;

    // Control register field positions
    localparam int unsigned CB_HMODE = 1;
    localparam int unsigned CB_DIR   = 2;
    localparam int unsigned CB_LCOMP = 3;
    localparam int unsigned CB_HOFF  = 4;
    localparam int unsigned CB_POINV = 5;
    localparam int unsigned CB_PRE   = 6;
    localparam int unsigned CB_ENA   = 9;
    localparam int unsigned CB_INV1  = 11;
    localparam int unsigned CB_INV3  = 12;

    localparam logic [15:0] CTRL_RESET  = 16'h0012;
    localparam logic [3:0]  HOFF_LEVELS = 4'h5;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage

`default_nettype wire

/* File: common/chan_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface chan_if;
    logic        tick;
    logic [15:0] len;
    logic [15:0] cmp_first;
    logic [15:0] cmp_second;
    logic [15:0] cmp_third;
    logic        hi;
    logic        lo;
    logic        wrap;
    logic        load;

    modport ctl (output tick, len, cmp_first, cmp_second, cmp_third,
                 input hi, lo, wrap, load);
    modport gen (input tick, len, cmp_first, cmp_second, cmp_third,
                 output hi, lo, wrap, load);
endinterface

`default_nettype wire

/* File: hw/pwm_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none

module pwm_prescaler
    import pwm_pkg::*;
(
    input  wire logic       clk,   // Core clock
    input  wire logic       rst_n, // Async reset
    input  wire logic [2:0] sel,   // Divide select
    output logic            tick   // One pulse per divided period
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } div_s;

    div_s       s_q;
    div_s       s_d;
    logic [7:0] mask;

    always_comb begin
        mask = 8'((9'h002 << sel) - 9'h001);
        s_d.cnt = s_q.cnt + 8'h01;
        s_d.tick = (s_q.cnt & mask) == mask;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    // Smallest divisor is two, so ticks are never adjacent
    AST_TICK_GAP: assert property (@(posedge clk) disable iff (!rst_n)
        tick |=> !tick)
        else $error("prescaler ticks on two adjacent clocks");
endmodule

`default_nettype wire

/* File: hw/pwm_pair.sv */
`timescale 1ns/1ps
`default_nettype none

module pwm_pair
    import pwm_pkg::*;
(
    input  wire logic clk,   // Core clock
    input  wire logic rst_n, // Async reset
    chan_if.gen       ch     // Timer settings and waveforms
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        hi;
        logic        lo;
        logic        wrap;
        logic        load;
    } pair_s;

    pair_s       s_q;
    pair_s       s_d;
    logic [15:0] nxt;

    always_comb begin
        s_d = s_q;
        s_d.wrap = 1'b0;
        s_d.load = 1'b0;
        nxt = (s_q.cnt == ch.len) ? 16'h0000 : s_q.cnt + 16'h0001;
        if (ch.tick) begin
            s_d.cnt = nxt;
            s_d.wrap = s_q.cnt == ch.len;
            s_d.load = (s_q.cnt == 16'h0000) && (nxt == 16'h0001);
            // Falling edge wins if both compares hit together
            if (nxt == ch.cmp_second) begin
                s_d.hi = 1'b0;
            end else if (nxt == ch.cmp_first) begin
                s_d.hi = 1'b1;
            end
            if (nxt == ch.cmp_third || (s_q.hi && !s_d.hi)) begin
                s_d.lo = 1'b0;
            end else if (nxt == ch.len) begin
                s_d.lo = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign ch.hi = s_q.hi;
    assign ch.lo = s_q.lo;
    assign ch.wrap = s_q.wrap;
    assign ch.load = s_q.load;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_hi_fall;
        s_q.hi ##1 !s_q.hi;
    endsequence

    AST_CNT_WRAP: assert property (ch.tick && s_q.cnt == ch.len |=> s_q.cnt == 16'h0000)
        else $error("timer did not restart after period length");
    AST_CNT_STEP: assert property (ch.tick && s_q.cnt != ch.len |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
        else $error("timer did not advance on tick");
    AST_HI_RISE: assert property (ch.tick && nxt == ch.cmp_first && nxt != ch.cmp_second |=> s_q.hi)
        else $error("high side missed first compare");
    AST_HI_FALL: assert property (ch.tick && nxt == ch.cmp_second |=> !s_q.hi)
        else $error("high side missed second compare");
    AST_LO_RISE: assert property (ch.tick && nxt == ch.len && nxt != ch.cmp_third && !(s_q.hi && !s_d.hi) |=> s_q.lo)
        else $error("low side missed period length");
    AST_LO_FALL: assert property (seq_hi_fall |-> !s_q.lo)
        else $error("low side stayed high after high side fell");
endmodule

`default_nettype wire

/* File: hw/hbridge_pwm_generator.sv */
// Functional notes
// - Five PWM outputs, usable for an H-bridge or as plain PWM.
// - After reset the block sits in H-bridge mode with the motor off.
// - Standard mode groups outputs into two pairs plus the fifth output, each with one period.
// - Software sets each pair's period and each output's duty.
// - Timer clock is core clock divided by 2 up to 256.
// - Each pair's period comes from its period-length register.
// - Waveforms come from comparing a 16-bit timer with compare values.
// - High side rises at first compare, falls at second compare.
// - Low side rises when the timer reaches the period length.
// - Low side falls at third compare or when high side falls.
// - Pairs have three compares and a length; fifth output two and a length.
// - Prescale code 000 divides by 2, rising to 111 for 256.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module hbridge_pwm_generator
    import pwm_pkg::*;
(
    input  wire logic        clk,           // 40 MHz core clock
    input  wire logic        rst_n,         // Async reset
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    output logic [4:0]       pwm_out,       // PWM pins
    output logic             irq            // Level interrupt
);
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_e;

    typedef struct packed {
        wr_e               wst;
        logic              aw_got;
        logic              w_got;
        logic [7:0]        awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [11:0][15:0] regs;
        logic [2:0][2:0][15:0] act;
        logic [2:0]        stat;
        logic [2:0]        mask;
        logic [4:0]        out;
        logic              irq;
    } top_s;

    top_s       s_q;
    top_s       s_d;
    logic       tick;
    logic [3:0] widx;
    logic [3:0] ridx;
    logic [4:0] o;
    logic [15:0] ctrl;

    chan_if p0 ();
    chan_if p1 ();
    chan_if sg ();

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[7:6] == 2'b00) && (a[5:2] <= IDX_MASK);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
        logic [15:0] r;
        r[15:8] = strb[1] ? data[15:8] : old[15:8];
        r[7:0] = strb[0] ? data[7:0] : old[7:0];
        return r;
    endfunction

    pwm_prescaler u_presc (
        .clk   (clk),
        .rst_n (rst_n),
        .sel   (s_q.regs[IDX_CTRL][CB_PRE +: 3]),
        .tick  (tick)
    );

    pwm_pair u_pair0 (
        .clk   (clk),
        .rst_n (rst_n),
        .ch    (p0)
    );

    pwm_pair u_pair1 (
        .clk   (clk),
        .rst_n (rst_n),
        .ch    (p1)
    );

    pwm_pair u_single (
        .clk   (clk),
        .rst_n (rst_n),
        .ch    (sg)
    );

    // Lengths act at once; compares go through the load copies
    assign p0.tick = tick;
    assign p0.len = s_q.regs[IDX_P0_LEN];
    assign p0.cmp_first = s_q.act[0][0];
    assign p0.cmp_second = s_q.act[0][1];
    assign p0.cmp_third = s_q.act[0][2];

    assign p1.tick = tick;
    assign p1.len = s_q.regs[IDX_P1_LEN];
    assign p1.cmp_first = s_q.act[1][0];
    assign p1.cmp_second = s_q.act[1][1];
    assign p1.cmp_third = s_q.act[1][2];

    assign sg.tick = tick;
    assign sg.len = s_q.regs[IDX_S_LEN];
    assign sg.cmp_first = s_q.act[2][0];
    assign sg.cmp_second = s_q.act[2][1];
    assign sg.cmp_third = s_q.act[2][2];

    assign ctrl = s_q.regs[IDX_CTRL];

    always_comb begin
        s_d = s_q;
        widx = 4'h0;
        ridx = s_axi_araddr[5:2];
        o = 5'h00;

        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_got = 1'b1;
            s_d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata;
            s_d.wstrb = s_axi_wstrb;
        end

        case (s_q.wst)
            WR_IDLE: begin
                if (s_d.aw_got && s_d.w_got) begin
                    widx = s_d.awaddr[5:2];
                    s_d.aw_got = 1'b0;
                    s_d.w_got = 1'b0;
                    s_d.bvalid = 1'b1;
                    s_d.wst = WR_RESP;
                    s_d.bresp = RESP_SLVERR;
                    if (addr_ok(s_d.awaddr)) begin
                        s_d.bresp = RESP_OKAY;
                        if (widx == IDX_ICLR) begin
                            if (s_d.wstrb[0]) begin
                                s_d.stat = s_q.stat & ~s_d.wdata[2:0];
                            end
                        end else if (widx == IDX_MASK) begin
                            if (s_d.wstrb[0]) begin
                                s_d.mask = s_d.wdata[2:0];
                            end
                        end else begin
                            s_d.regs[widx] = merge(s_q.regs[widx], s_d.wdata,
                                                   s_d.wstrb);
                        end
                    end
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    s_d.bvalid = 1'b0;
                    s_d.wst = WR_IDLE;
                end
            end
            default: begin
                s_d.bvalid = 1'b0;
                s_d.wst = WR_IDLE;
            end
        endcase

        if (s_axi_arvalid && s_axi_arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = 32'h0000_0000;
            s_d.rresp = RESP_SLVERR;
            if (addr_ok(s_axi_araddr)) begin
                s_d.rresp = RESP_OKAY;
                if (ridx == IDX_ICLR) begin
                    s_d.rdata[2:0] = s_q.stat;
                end else if (ridx == IDX_MASK) begin
                    s_d.rdata[2:0] = s_q.mask;
                end else begin
                    s_d.rdata[15:0] = s_q.regs[ridx];
                end
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Set after clear, so a period end in the clearing cycle survives
        s_d.stat = s_d.stat | {sg.wrap, p1.wrap, p0.wrap};
        s_d.irq = |(s_d.stat & s_d.mask);

        // Compares only change at a period start, avoiding torn pulses
        if (ctrl[CB_LCOMP]) begin
            if (p0.load) begin
                s_d.act[0] = {s_q.regs[IDX_P0_C2], s_q.regs[IDX_P0_C1],
                              s_q.regs[IDX_P0_C0]};
            end
            if (p1.load) begin
                s_d.act[1] = {s_q.regs[IDX_P1_C2], s_q.regs[IDX_P1_C1],
                              s_q.regs[IDX_P1_C0]};
            end
            if (sg.load) begin
                s_d.act[2] = {16'h0000, s_q.regs[IDX_S_C1],
                              s_q.regs[IDX_S_C0]};
            end
        end

        if (ctrl[CB_HMODE]) begin
            if (ctrl[CB_HOFF]) begin
                o[3:0] = HOFF_LEVELS;
            end else if (!ctrl[CB_ENA]) begin
                o[3:0] = 4'h0;
            end else if (ctrl[CB_DIR]) begin
                o[3:0] = {2'b00, p0.lo, p0.hi};
            end else begin
                o[3:0] = {p1.lo, p1.hi, 2'b00};
            end
        end else begin
            o[3:0] = {p1.lo, p1.hi, p0.lo, p0.hi};
        end
        o[4] = sg.hi;
        o[1] = o[1] ^ ctrl[CB_INV1];
        o[3] = o[3] ^ ctrl[CB_INV3];
        if (ctrl[CB_POINV]) begin
            o = ~o;
        end
        s_d.out = o;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.wst <= WR_IDLE;
            s_q.regs[IDX_CTRL] <= CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = (s_q.wst == WR_IDLE) && !s_q.aw_got;
    assign s_axi_wready = (s_q.wst == WR_IDLE) && !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign pwm_out = s_q.out;
    assign irq = s_q.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence seq_plain_hbridge;
        ctrl[CB_HMODE] && !ctrl[CB_POINV] && !ctrl[CB_INV1] && !ctrl[CB_INV3];
    endsequence

    sequence seq_plain_std;
        !ctrl[CB_HMODE] && !ctrl[CB_POINV] && !ctrl[CB_INV1] && !ctrl[CB_INV3];
    endsequence

    AST_HOFF_FORCE: assert property (seq_plain_hbridge and ctrl[CB_HOFF] |=> pwm_out[3:0] == 4'h5)
        else $error("high side off did not force motor off levels");

    AST_DIR_STEER: assert property (seq_plain_hbridge and (!ctrl[CB_HOFF] && ctrl[CB_ENA] && ctrl[CB_DIR])
        |=> pwm_out[3:2] == 2'b00 && pwm_out[1:0] == $past({p0.lo, p0.hi}))
        else $error("direction steering wrong");

    AST_STD_PAIRS: assert property (seq_plain_std |=> pwm_out[3:0] == $past({p1.lo, p1.hi, p0.lo, p0.hi}))
        else $error("standard mode pairs not routed");

    AST_SINGLE_OUT: assert property (!ctrl[CB_POINV] |=> pwm_out[4] == $past(sg.hi))
        else $error("fifth output not following its timer");

    AST_TICK_DIV2: assert property (tick && ctrl[CB_PRE +: 3] == 3'h0 && s_d.regs[IDX_CTRL][CB_PRE +: 3] == 3'h0
        |=> !tick ##1 tick)
        else $error("code zero does not divide by two");

    AST_LCOMP_LOAD: assert property (ctrl[CB_LCOMP] && p0.load |=> s_q.act[0][0] == $past(s_q.regs[IDX_P0_C0]))
        else $error("compare copy not loaded at period start");

    AST_REG_WRITE: assert property (s_q.wst == WR_IDLE && s_d.wst == WR_RESP && s_d.bresp == RESP_OKAY
        && widx == IDX_P0_LEN && s_d.wstrb[1:0] == 2'b11
        |=> s_q.regs[IDX_P0_LEN] == $past(s_d.wdata[15:0]) ##1 s_q.wst == WR_RESP || !s_q.bvalid)
        else $error("period length write lost");

    // Mask as written this cycle, so a mask write landing with the wrap is honoured
    AST_IRQ_RAISE: assert property (sg.wrap && s_d.mask[2] |=> irq && s_q.stat[2])
        else $error("unmasked event did not raise interrupt");
endmodule

`default_nettype wire

/* File: verification/hbridge_load_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Power stage stand-in: tallies how many clocks each switch is driven on.
// Counting whole periods makes the tally independent of the timer phase.
module hbridge_load_model (
    input  wire logic        clk,        // Core clock
    input  wire logic [4:0]  gate,       // PWM pins
    input  wire logic        clr,        // Zero the tallies
    input  wire logic        meas,       // Count window open
    output logic      [15:0] on_cnt [5]  // On clocks per pin
);
    always_ff @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (clr) begin
                on_cnt[i] <= 16'h0;
            end else if (meas && gate[i]) begin
                on_cnt[i] <= on_cnt[i] + 16'h1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import pwm_pkg::*;
();
    logic        clk;
    logic        rst_n;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic [4:0]  pwm_out;
    logic        irq;
    logic        clr;
    logic        meas;
    logic [15:0] on_cnt [5];
    logic [31:0] rd;
    logic [1:0]  rs;
    int          mismatches;
    int          total_checks;
    int          t0;
    int          cyc = 0;

    // Entry 0 unused, then pair0 first/second/third/length, pair1 same, single first/second/length
    localparam logic [15:0] vals [12] = '{16'h0, 16'h1, 16'h4, 16'h6, 16'h7, 16'h1,
                                           16'h3, 16'h1, 16'h5, 16'h2, 16'h7, 16'h9};
    localparam logic [15:0] ctl [9] = '{16'h0008, 16'h020e, 16'h020a, 16'h000e, 16'h001e,
                                        16'h0028, 16'h1808, 16'h0000, 16'h0008};
    // On clocks in 240 (periods 16, 12, 20 at divide-by-2), {out4 .. out0}
    localparam logic [39:0] expd [9] = '{40'h78_50_50_96_5a, 40'h78_00_00_96_5a,
                                         40'h78_50_50_00_00, 40'h78_00_00_00_00,
                                         40'h78_00_f0_00_f0, 40'h78_a0_a0_5a_96,
                                         40'h78_a0_50_5a_5a, 40'h78_50_50_96_5a,
                                         40'h48_50_50_96_5a};

    hbridge_pwm_generator dut (
        .clk           (clk),
        .rst_n         (rst_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .pwm_out       (pwm_out),
        .irq           (irq)
    );

    hbridge_load_model load (
        .clk    (clk),
        .gate   (pwm_out),
        .clr    (clr),
        .meas   (meas),
        .on_cnt (on_cnt)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    function automatic logic [7:0] ad(input logic [3:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ready is looked at on the falling edge; nothing moves between it and
    // the next rising edge, so this is the value the handshake edge sees.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta || (s_axi_awvalid && s_axi_awready);
            tw = tw || (s_axi_wvalid && s_axi_wready);
            @(posedge clk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk);
        end while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        s_axi_rready  <= 1'b1;
        do begin
            @(negedge clk);
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic reg_wr(input logic [3:0] idx, input logic [31:0] d);
        axi_wr(ad(idx), d, rs);
        chk("write resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask

    task automatic reg_chk(input string what, input logic [3:0] idx, input logic [31:0] exp);
        axi_rd(ad(idx), rd, rs);
        chk(what, exp, rd);
        chk("read resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    endtask

    task automatic measure(input logic [39:0] exp);
        clr <= 1'b1;
        @(posedge clk);
        clr  <= 1'b0;
        meas <= 1'b1;
        repeat (240) @(posedge clk);
        meas <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            chk("on time", {24'h0, exp[i*8 +: 8]}, {16'h0, on_cnt[i]});
        end
    endtask

    task automatic rise4();
        do begin
            @(negedge clk);
        end while (pwm_out[4]);
        do begin
            @(negedge clk);
        end while (!pwm_out[4]);
    endtask

    initial begin
        rst_n         = 1'b0;
        s_axi_awaddr  = 8'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0;
        s_axi_wstrb   = 4'hf;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        clr           = 1'b1;
        meas          = 1'b0;
        mismatches    = 0;
        total_checks  = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        reg_chk("ctrl reset", IDX_CTRL, {16'h0, CTRL_RESET});
        chk("pins after reset", 32'h5, {27'h0, pwm_out});
        for (int i = 1; i < 12; i++) begin
            reg_wr(4'(i), 32'ha5a5_0000 | {16'h0, vals[i]});
            reg_chk("reg readback", 4'(i), {16'h0, vals[i]});
        end
        axi_wr(8'h38, 32'h1, rs);
        chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        axi_rd(8'h40, rd, rs);
        chk("unmapped read data", 32'h0, rd);
        chk("unmapped read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        // Modes, inversions, held compare copies, then a fresh load
        for (int i = 0; i < 9; i++) begin
            reg_wr(IDX_CTRL, {16'h0, ctl[i]});
            if (i == 7) begin
                reg_wr(IDX_S_C1, 32'h5);
            end
            repeat (300) @(posedge clk);
            measure(expd[i]);
        end
        for (int s = 0; s < 8; s++) begin
            reg_wr(IDX_CTRL, 32'h8 | 32'(s << CB_PRE));
            rise4();
            t0 = cyc;
            rise4();
            chk("single period", 32'(10 << (s + 1)), 32'(cyc - t0));
            @(posedge clk);
        end
        reg_chk("status set", IDX_ICLR, 32'h7);
        // A full single period, so a wrap meets the open mask bit
        reg_wr(IDX_MASK, 32'h4);
        repeat (2600) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        reg_wr(IDX_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        // Longest periods so that no wrap refills the status meanwhile
        reg_wr(IDX_P0_LEN, 32'hffff);
        reg_wr(IDX_P1_LEN, 32'hffff);
        reg_wr(IDX_S_LEN, 32'hffff);
        reg_wr(IDX_ICLR, 32'h7);
        reg_wr(IDX_MASK, 32'h7);
        reg_chk("status cleared", IDX_ICLR, 32'h0);
        chk("irq after clear", 32'h0, {31'h0, irq});
        // Upper byte only: the lower byte must keep its earlier value
        s_axi_wstrb <= 4'h2;
        reg_wr(IDX_S_C0, 32'h1234);
        s_axi_wstrb <= 4'hf;
        reg_chk("byte strobe", IDX_S_C0, 32'h1202);
        tally_and_finish();
    end

    initial begin
        repeat (80000) @(posedge clk);
        mismatches++;
        $display("CHECK FAILED watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule

`default_nettype wire
